// >>> logic/dkas_defines.vh
// Constants for the debug key access sequencer
`ifndef DKAS_DEFINES_VH
`define DKAS_DEFINES_VH
`define DKAS_KEY_ERASE 64'h4E564D4572617365
`define DKAS_KEY_NVM 64'h4E564D50726F6720
`define DKAS_KEY_ROW 64'h4E564D5573267465
`define DKAS_RST_SIG 8'h59
`define DKAS_ROW_BYTES 6'h20
`define DKAS_ROW_AW 5
`define DKAS_ERASE_TIME_NS 1000
`define DKAS_ERASE_CYC ((`DKAS_ERASE_TIME_NS + 7) / 8)
`define DKAS_CTRL_RST 8'h01
`define DKAS_CTRL_HOLD_BIT 0
`define DKAS_CTRL_DONE_BIT 1
`define DKAS_KS_ERASE_BIT 3
`define DKAS_KS_NVM_BIT 4
`define DKAS_KS_ROW_BIT 5
`endif

// >>> logic/dkas_key_shifter.v
// Key shift register and signature decoder
`timescale 1ns/10ps
`default_nettype none
`include "dkas_defines.vh"
module dkas_key_shifter (
	input wire clk,
	input wire rst,
	input wire key_bit_valid,
	input wire key_bit,
	input wire key_end,
	output reg match_erase,
	output reg match_nvm,
	output reg match_row
);
	reg [63:0] shift_reg;
	// Shift in LSB first: new bits enter at the top, so after 64 the first bit is bit 0
	always @(posedge clk)
	begin
		if (rst)
			shift_reg <= 64'h0000000000000000;
		else if (key_bit_valid)
			shift_reg <= {key_bit, shift_reg[63:1]};
	end
	// One-cycle match pulses on key end; no match gives no pulse
	always @(posedge clk)
	begin
		if (rst)
		begin
			match_erase <= 1'b0;
			match_nvm <= 1'b0;
			match_row <= 1'b0;
		end
		else
		begin
			match_erase <= key_end && (shift_reg == `DKAS_KEY_ERASE);
			match_nvm <= key_end && (shift_reg == `DKAS_KEY_NVM);
			match_row <= key_end && (shift_reg == `DKAS_KEY_ROW);
		end
	end
endmodule // dkas_key_shifter
`default_nettype wire

// >>> logic/dkas_sequencer.v
// Debug key access sequencer top
`timescale 1ns/10ps
`default_nettype none
`include "dkas_defines.vh"
// Notes on behaviour
// - NVM key needs unlocked and program flag
// - Row key needs locked and row flag
// - Three 64-bit keys, LSB first
// - Lock state one during erase, zero after success
// - Erase failure flag zero means success
// - Locked refuses system bus, CS only
// - Brown-out forced active during erase
// - NVM key plus reset sets program flag
// - Row key plus reset sets row flag
// - Row mode writes only first 32 bytes
// - Row mode returns no RAM reads
// - Done bit copies buffer, clears row flag
// - One-cycle pulse event per sync rising edge
// - Event generator only, no event user
// - Interface runs in every sleep mode
// - Request system clock with clock hold; no access asleep without it
// - Readable system sleep flag
// - Clock hold keeps clock, emulates sleep
// - Clock hold reads one when enabled
// - Erase key dropped on disable or reset
// - NVM key status clears when flag sets
// - Erase key cleared by reset request
module dkas_sequencer (
	input wire clk,
	input wire rst,
	input wire if_enable,
	input wire key_bit_valid,
	input wire key_bit,
	input wire key_end,
	input wire rst_req_wr,
	input wire [7:0] rst_req_data,
	input wire key_status_wr,
	input wire [7:0] key_status_data,
	input wire ctrl_wr,
	input wire [7:0] ctrl_data,
	input wire lock_bits,
	input wire erase_done,
	input wire erase_error,
	input wire row_copy_done,
	input wire sys_sleeping,
	input wire sync_line,
	input wire ram_wr,
	input wire ram_rd,
	input wire [15:0] ram_addr,
	input wire [7:0] ram_wdata,
	input wire [7:0] sys_rdata,
	input wire bus_req,
	output reg [7:0] key_status_reg,
	output reg [7:0] system_status_reg,
	output reg [7:0] system_control_reg,
	output reg sys_reset_out,
	output reg erase_start,
	output reg bod_force_on,
	output reg row_copy_start,
	output reg [7:0] row_rd_data,
	output reg [7:0] ram_rdata,
	output reg bus_grant,
	output reg sys_clock_request,
	output reg sync_event
);
	// ==========================================
	// State
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_ERASE = 4'b0010;
	localparam [3:0] ST_COPY = 4'b0100;
	localparam [3:0] ST_DONE = 4'b1000;
	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg erase_key_status;
	reg nvm_program_key;
	reg locked_row_write_key;
	reg row_program_active;
	reg nvm_prog_flag;
	reg lock_state;
	reg erase_failure_flag;
	reg system_clock_hold;
	reg row_load_complete;
	reg reset_active;
	reg sync_prev;
	reg [7:0] row_buf [0:31];
	reg [4:0] copy_idx;
	wire match_erase;
	wire match_nvm;
	wire match_row;
	wire kill;
	wire rst_assert;
	wire rst_release;
	wire allowed;
	// Write hits the staging buffer window
	function in_row_window;
		input [15:0] a;
		begin
			in_row_window = (a < {10'h000, `DKAS_ROW_BYTES});
		end
	endfunction
	// Erase launch: idle, erase key held and reset signature written
	function erase_launch;
		input [3:0] st;
		input req;
		input key;
		begin
			erase_launch = (st == ST_IDLE) && req && key;
		end
	endfunction
	// Disable or interface reset drops every key
	assign kill = rst || !if_enable;
	assign rst_assert = rst_req_wr && (rst_req_data == `DKAS_RST_SIG);
	assign rst_release = rst_req_wr && (rst_req_data == 8'h00) && reset_active;
	// Bus allowed only unlocked, not in row mode, and with a running clock
	assign allowed = !lock_state && !lock_bits && !row_program_active
		&& (!sys_sleeping || system_clock_hold);
	dkas_key_shifter u_keys (
		.clk(clk),
		.rst(kill),
		.key_bit_valid(key_bit_valid),
		.key_bit(key_bit),
		.key_end(key_end),
		.match_erase(match_erase),
		.match_nvm(match_nvm),
		.match_row(match_row)
	);
	// ==========================================
	// Key status bits
	always @(posedge clk)
	begin
		if (kill)
		begin
			erase_key_status <= 1'b0;
			nvm_program_key <= 1'b0;
			locked_row_write_key <= 1'b0;
		end
		else
		begin
			if (match_erase)
				erase_key_status <= 1'b1;
			else if (rst_assert)
				erase_key_status <= 1'b0;
			if (match_nvm)
				nvm_program_key <= 1'b1;
			else if (nvm_prog_flag)
				nvm_program_key <= 1'b0;
			if (match_row)
				locked_row_write_key <= 1'b1;
			else if (key_status_wr && key_status_data[`DKAS_KS_ROW_BIT])
				locked_row_write_key <= 1'b0;
		end
	end
	// ==========================================
	// Reset request, erase and mode flags
	always @(posedge clk)
	begin
		if (kill)
		begin
			reset_active <= 1'b0;
			nvm_prog_flag <= 1'b0;
			row_program_active <= 1'b0;
			erase_failure_flag <= 1'b0;
		end
		else
		begin
			if (rst_assert)
				reset_active <= 1'b1;
			else if (rst_release)
				reset_active <= 1'b0;
			// NVM mode on release when unlocked with key; next reset ends it
			if (rst_release && nvm_program_key && !lock_bits)
				nvm_prog_flag <= 1'b1;
			else if (rst_assert)
				nvm_prog_flag <= 1'b0;
			if (rst_release && locked_row_write_key && lock_bits)
				row_program_active <= 1'b1;
			else if (state_reg == ST_DONE)
				row_program_active <= 1'b0;
			if (state_reg == ST_ERASE && erase_done)
				erase_failure_flag <= erase_error;
			else if (rst_assert && erase_key_status)
				erase_failure_flag <= 1'b0;
		end
	end
	// Lock state: set by erase start, cleared on success, else follows fuses
	always @(posedge clk)
	begin
		if (rst)
			lock_state <= 1'b1;
		else if (state_reg == ST_ERASE)
			lock_state <= erase_done ? erase_error : 1'b1;
		else
			lock_state <= lock_bits;
	end
	// ==========================================
	// Sequencer
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (erase_launch(state_reg, rst_assert, erase_key_status))
					state_next = ST_ERASE;
				else if (row_program_active && row_load_complete)
					state_next = ST_COPY;
			ST_ERASE:
				if (erase_done)
					state_next = ST_IDLE;
			ST_COPY:
				if (row_copy_done)
					state_next = ST_DONE;
			ST_DONE:
				state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end
	always @(posedge clk)
	begin
		if (kill)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end
	// ==========================================
	// Control register: clock hold and done bit
	always @(posedge clk)
	begin
		if (kill)
		begin
			system_clock_hold <= 1'b1;
			row_load_complete <= 1'b0;
		end
		else
		begin
			if (ctrl_wr)
				system_clock_hold <= ctrl_data[`DKAS_CTRL_HOLD_BIT];
			if (ctrl_wr && ctrl_data[`DKAS_CTRL_DONE_BIT] && row_program_active)
				row_load_complete <= 1'b1;
			else if (state_reg == ST_DONE)
				row_load_complete <= 1'b0;
		end
	end
	// ==========================================
	// Row staging buffer, write-only in row mode
	always @(posedge clk)
	begin
		if (row_program_active && ram_wr && in_row_window(ram_addr))
			row_buf[ram_addr[`DKAS_ROW_AW-1:0]] <= ram_wdata;
	end
	// Copy index walks the buffer while copying
	always @(posedge clk)
	begin
		if (kill || state_reg != ST_COPY)
			copy_idx <= 5'h00;
		else
			copy_idx <= copy_idx + 5'h01;
	end
	// ==========================================
	// Registered outputs
	always @(posedge clk)
	begin
		if (rst)
		begin
			key_status_reg <= 8'h00;
			system_status_reg <= 8'h01;
			system_control_reg <= `DKAS_CTRL_RST;
			sys_reset_out <= 1'b0;
			erase_start <= 1'b0;
			bod_force_on <= 1'b0;
			row_copy_start <= 1'b0;
			row_rd_data <= 8'h00;
			ram_rdata <= 8'h00;
			bus_grant <= 1'b0;
			sys_clock_request <= 1'b0;
			sync_event <= 1'b0;
			sync_prev <= 1'b0;
		end
		else
		begin
			key_status_reg <= {2'b00, locked_row_write_key, nvm_program_key, erase_key_status, 3'b000};
			system_status_reg <= {1'b0, erase_failure_flag, reset_active, sys_sleeping,
				nvm_prog_flag, row_program_active, 1'b0, lock_state};
			system_control_reg <= {6'h00, row_load_complete, system_clock_hold};
			sys_reset_out <= reset_active;
			erase_start <= erase_launch(state_reg, rst_assert, erase_key_status);
			bod_force_on <= (state_reg == ST_ERASE);
			row_copy_start <= (state_reg == ST_IDLE) && row_program_active && row_load_complete;
			row_rd_data <= row_buf[copy_idx];
			// No RAM data while staging the row
			ram_rdata <= (ram_rd && !row_program_active) ? sys_rdata : 8'h00;
			bus_grant <= bus_req && allowed;
			sys_clock_request <= if_enable && system_clock_hold;
			// One-cycle pulse event per rising edge on sync line; no disable path
			sync_prev <= sync_line;
			sync_event <= sync_line && !sync_prev;
		end
	end
endmodule // dkas_sequencer
`default_nettype wire

// >>> verification/dkas_asserts.sv
// Port checks for the key access sequencer
`timescale 1ns/10ps
`default_nettype none
module dkas_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic if_enable,
	input wire logic rst_req_wr,
	input wire logic [7:0] rst_req_data,
	input wire logic lock_bits,
	input wire logic erase_done,
	input wire logic [7:0] key_status_reg,
	input wire logic [7:0] system_status_reg,
	input wire logic [7:0] system_control_reg,
	input wire logic sys_reset_out,
	input wire logic erase_start,
	input wire logic row_copy_start,
	input wire logic bod_force_on,
	input wire logic [7:0] ram_rdata,
	input wire logic bus_grant,
	input wire logic sys_clock_request,
	input wire logic sync_event
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// System reset follows the request register: request flag, then output flop
	property p_rst_on; rst_req_wr && rst_req_data == 8'h59 |-> ##2 sys_reset_out; endproperty
	property p_rst_off; rst_req_wr && rst_req_data == 8'h00 |-> ##2 !sys_reset_out; endproperty
	// Erase launch, then key drop one edge later, forced brown-out and lock state
	property p_erase; key_status_reg[3] && rst_req_wr && rst_req_data == 8'h59 |=> erase_start ##1 !key_status_reg[3];
	endproperty
	property p_bod; erase_start |=> bod_force_on ##1 system_status_reg[0]; endproperty
	// Copy starts only in row mode
	property p_copy; row_copy_start |-> system_status_reg[2]; endproperty
	property p_bod_end; erase_done && bod_force_on |-> ##[1:2] !bod_force_on; endproperty
	// Access refusals
	property p_grant; lock_bits |=> !bus_grant; endproperty
	property p_row_rd; system_status_reg[2] ##1 system_status_reg[2] |-> ram_rdata == 8'h00; endproperty
	// Defaults, disable and event pulse
	property p_hold; $fell(rst) |-> system_control_reg == 8'h01; endproperty
	// Key flops clear on the first low edge, the status word one edge later
	property p_dis; !if_enable ##1 !if_enable |=> key_status_reg == 8'h00 && !sys_clock_request; endproperty
	property p_sync; sync_event |=> !sync_event; endproperty
	a_rst_on: assert property (p_rst_on) else $error("reset not raised");
	a_rst_off: assert property (p_rst_off) else $error("reset not released");
	a_erase: assert property (p_erase) else $error("erase start or key clear missing");
	a_bod: assert property (p_bod) else $error("brown-out or lock state missing");
	a_bod_end: assert property (p_bod_end) else $error("brown-out held after erase");
	a_grant: assert property (p_grant) else $error("bus granted while locked");
	a_row_rd: assert property (p_row_rd) else $error("data read in row mode");
	a_hold: assert property (p_hold) else $error("clock hold default wrong");
	a_dis: assert property (p_dis) else $error("keys kept on disable");
	a_sync: assert property (p_sync) else $error("event longer than a cycle");
	a_copy: assert property (p_copy) else $error("copy started outside row mode");
	c_copy: cover property (row_copy_start);
	c_erase: cover property (erase_start);
	c_row: cover property (system_status_reg[2]);
	c_sync: cover property (sync_event);
endmodule // dkas_asserts
bind dkas_sequencer dkas_asserts i_dkas_asserts (.*);
`default_nettype wire

// >>> verification/dkas_nvm_model.sv
// Behavioural NVM, lock fuse and erase controller
`timescale 1ns/10ps
`default_nettype none
module dkas_nvm_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic set_lock,
	input wire logic fail_mode,
	input wire logic erase_start,
	input wire logic row_copy_start,
	output logic lock_bits,
	output logic erase_done,
	output wire logic erase_error,
	output logic row_copy_done
);
	logic [3:0] cnt_reg;
	logic kind_reg;
	// Failure level is sampled with the done pulse
	assign erase_error = fail_mode;
	// Erase and copy finish after a fixed busy time
	always @(posedge clk)
	begin
		erase_done <= 1'b0;
		row_copy_done <= 1'b0;
		if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
		if (cnt_reg == 4'h1)
		begin
			erase_done <= kind_reg;
			row_copy_done <= !kind_reg;
			if (kind_reg && !fail_mode)
				lock_bits <= 1'b0; // Lock fuse cleared only on success
		end
		if (erase_start || row_copy_start)
		begin
			cnt_reg <= 4'hF;
			kind_reg <= erase_start;
		end
		if (set_lock || rst)
			lock_bits <= 1'b1;
		if (rst)
			cnt_reg <= 4'h0;
	end
endmodule // dkas_nvm_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the key access sequencer
`timescale 1ns/10ps
`default_nettype none
`include "dkas_defines.vh"
module tb;
	logic clk = 1'b0, rst = 1'b1, if_enable = 1'b1, key_bit_valid = 1'b0, key_bit = 1'b0, key_end = 1'b0;
	logic rst_req_wr = 1'b0, key_status_wr = 1'b0, ctrl_wr = 1'b0, sys_sleeping = 1'b0, sync_line = 1'b0;
	logic ram_wr = 1'b0, ram_rd = 1'b0, bus_req = 1'b1, set_lock = 1'b0, fail_mode = 1'b0;
	logic [7:0] rst_req_data = 8'h00, key_status_data = 8'h00, ctrl_data = 8'h00, ram_wdata = 8'h00;
	logic [7:0] sys_rdata = 8'hA5, key_status_reg, system_status_reg, system_control_reg, row_rd_data, ram_rdata;
	logic [15:0] ram_addr = 16'h0008;
	logic lock_bits, erase_done, erase_error, row_copy_done, sys_reset_out, erase_start, bod_force_on;
	logic row_copy_start, bus_grant, sys_clock_request, sync_event;
	int err_total = 0, compares = 0;
	always #4 clk = ~clk;
	dkas_sequencer i_dkas_sequencer (.*);
	dkas_nvm_model i_dkas_nvm_model (.*);
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask
	// Key bits go LSB first, then the compare strobe
	task automatic send_key(input logic [63:0] k);
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk);
			key_bit_valid <= 1'b1;
			key_bit <= k[i];
		end
		@(posedge clk);
		key_bit_valid <= 1'b0;
		key_end <= 1'b1;
		@(posedge clk);
		key_end <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// One write pulse: 0 reset request, 1 key status, 2 control, 3 buffer
	task automatic wr(input int sel, input logic [7:0] d);
		@(posedge clk);
		{rst_req_wr, key_status_wr, ctrl_wr, ram_wr} <= 4'h8 >> sel;
		{rst_req_data, key_status_data, ctrl_data, ram_wdata} <= {4{d}};
		@(posedge clk);
		{rst_req_wr, key_status_wr, ctrl_wr, ram_wr} <= 4'h0;
		repeat (3) @(posedge clk);
	endtask
	task automatic reset_pair();
		wr(0, `DKAS_RST_SIG);
		wr(0, 8'h00);
	endtask
	// One read pulse; data judged just after the edge that loads it
	task automatic rd(input logic [7:0] exp);
		@(posedge clk);
		ram_rd <= 1'b1;
		@(posedge clk);
		ram_rd <= 1'b0;
		#1 chk("ram read", exp, ram_rdata);
	endtask
	task automatic poll(input int b, input logic v);
		for (int n = 0; system_status_reg[b] !== v; n++)
		begin
			if (n == 300)
			begin
				chk("status poll", {7'h0, v}, {7'h0, system_status_reg[b]});
				conclude();
			end
			@(posedge clk);
		end
	endtask
	task automatic t_erase(input logic fail);
		fail_mode <= fail;
		send_key(`DKAS_KEY_ERASE);
		chk("erase key", 8'h08, key_status_reg);
		chk("grant locked", 8'h00, {7'h0, bus_grant});
		reset_pair();
		chk("erase busy", 8'h01, system_status_reg & 8'h01);
		chk("erase bod", 8'h01, {7'h0, bod_force_on});
		chk("erase key clr", 8'h00, key_status_reg & 8'h08);
		if (fail)
			poll(6, 1'b1);
		else
			poll(0, 1'b0);
		repeat (2) @(posedge clk);
		chk("erase result", fail ? 8'h41 : 8'h00, system_status_reg & 8'h41);
		chk("grant after", {7'h0, !fail}, {7'h0, bus_grant});
	endtask
	task automatic t_refuse();
		send_key(64'h0123456789ABCDEF);
		chk("unknown key", 8'h00, key_status_reg);
		send_key(`DKAS_KEY_NVM);
		reset_pair();
		chk("nvm locked", 8'h00, system_status_reg & 8'h08);
		// Interface disable drops the key that the lock refused
		if_enable <= 1'b0;
		repeat (3) @(posedge clk);
		chk("refused key drop", 8'h00, key_status_reg);
		if_enable <= 1'b1;
	endtask
	task automatic t_row();
		send_key(`DKAS_KEY_ROW);
		reset_pair();
		poll(2, 1'b1);
		wr(3, 8'h5A);
		// Same low address bits outside the window must be dropped
		ram_addr <= 16'h0028;
		wr(3, 8'hC3);
		ram_addr <= 16'h0008;
		rd(8'h00);
		wr(2, 8'h03);
		// Buffer byte 8 stands on the copy output ten edges after the edge that takes the done write
		repeat (7) @(posedge clk);
		#1 chk("row byte", 8'h5A, row_rd_data);
		poll(2, 1'b0);
		wr(1, 8'h20);
		chk("row key clr", 8'h00, key_status_reg & 8'h20);
		reset_pair();
	endtask
	task automatic t_nvm();
		send_key(`DKAS_KEY_NVM);
		chk("nvm key", 8'h10, key_status_reg);
		reset_pair();
		poll(3, 1'b1);
		chk("nvm key clr", 8'h00, key_status_reg);
		rd(8'hA5);
		reset_pair();
		chk("nvm flag end", 8'h00, system_status_reg & 8'h08);
	endtask
	task automatic t_sleep();
		sys_sleeping <= 1'b1;
		wr(2, 8'h00);
		chk("sleep flag", 8'h10, system_status_reg & 8'h10);
		chk("grant asleep", 8'h00, {7'h0, bus_grant});
		chk("clock request off", 8'h00, {7'h0, sys_clock_request});
		wr(2, 8'h01);
		chk("grant hold", 8'h01, {7'h0, bus_grant});
		chk("clock request on", 8'h01, {7'h0, sys_clock_request});
		sys_sleeping <= 1'b0;
	endtask
	task automatic t_sync_dis();
		int n;
		n = 0;
		for (int i = 0; i < 12; i++)
		begin
			@(posedge clk);
			sync_line <= i == 2 || i == 6;
			n += sync_event;
		end
		chk("sync events", 8'h02, n[7:0]);
		send_key(`DKAS_KEY_ERASE);
		if_enable <= 1'b0;
		repeat (3) @(posedge clk);
		chk("keys disabled", 8'h00, key_status_reg);
		if_enable <= 1'b1;
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("hold default", 8'h01, system_control_reg);
		t_erase(1'b1);
		t_refuse();
		t_row();
		t_erase(1'b0);
		t_nvm();
		t_sleep();
		t_sync_dis();
		conclude();
	end
endmodule // tb
`default_nettype wire
